// File: src/sfpb_pkg.sv
`default_nettype none
package sfpb_pkg;
  // ==========================================
  // Opcodes
  localparam logic [7:0] CMD_PAGE_READ   = 8'hD2;
  localparam logic [7:0] CMD_BUF1_RD_HS  = 8'hD4;
  localparam logic [7:0] CMD_BUF2_RD_HS  = 8'hD6;
  localparam logic [7:0] CMD_BUF1_RD_LS  = 8'hD1;
  localparam logic [7:0] CMD_BUF2_RD_LS  = 8'hD3;
  localparam logic [7:0] CMD_BUF1_WRITE  = 8'h84;
  localparam logic [7:0] CMD_BUF2_WRITE  = 8'h87;
  localparam logic [7:0] CMD_PROG_ER_B1  = 8'h83;
  localparam logic [7:0] CMD_PROG_ER_B2  = 8'h86;
  localparam logic [7:0] CMD_PROG_B1     = 8'h88;
  localparam logic [7:0] CMD_PROG_B2     = 8'h89;
  localparam logic [7:0] CMD_PAGE_ERASE  = 8'h81;
  // ==========================================
  // Address layout
  localparam int         OFF_W           = 10;
  localparam int         DOC_PAGE_W      = 13;
  localparam int         PAGE_POS_STD    = 10;
  localparam int         PAGE_POS_BIN    = 9;
  localparam logic [9:0] LAST_OFF_STD    = 10'h20F;
  localparam logic [9:0] LAST_OFF_BIN    = 10'h1FF;
  localparam logic [3:0] HDR_BYTES       = 4'h4;
  localparam logic [3:0] BUF_READ_START  = 4'h5;
  localparam logic [3:0] PAGE_READ_START = 4'h8;
  localparam logic [7:0] ERASED_BYTE     = 8'hFF;
  localparam int         FIFO_DEPTH      = 8;
  // ==========================================
  // Self-timed operation lengths
  localparam int CLK_PERIOD_NS               = 100;
  // Each must outlast the byte-by-byte page walk
  localparam int ERASE_PROGRAM_TIME_MAX_US   = 120;
  localparam int PROGRAM_TIME_MAX_US         = 70;
  localparam int PAGE_ERASE_TIME_MAX_US      = 60;
  localparam logic [15:0] ERASE_PROGRAM_CYC  =
    16'(ERASE_PROGRAM_TIME_MAX_US * 1000 / CLK_PERIOD_NS);
  localparam logic [15:0] PROGRAM_CYC        =
    16'(PROGRAM_TIME_MAX_US * 1000 / CLK_PERIOD_NS);
  localparam logic [15:0] PAGE_ERASE_CYC     =
    16'(PAGE_ERASE_TIME_MAX_US * 1000 / CLK_PERIOD_NS);
  // ==========================================
  // States
  typedef enum {LK_IDLE, LK_HDR, LK_DOUT, LK_DIN, LK_SKIP} sfpb_link_t;
  typedef enum {OP_IDLE, OP_ERASE, OP_PROG, OP_WAIT} sfpb_op_t;
endpackage
`default_nettype wire

// File: src/sfpb_top.sv
// Contract
// R1 - Page read 528 mode: D2H, 13-bit page, 10-bit byte, four dummies.
// R2 - Page read 512 mode: 22-bit address, 13 page bits, 9 byte bits.
// R3 - After dummies, array data shifts out; buffers stay untouched.
// R4 - Page read offset wraps to start of the same page.
// R5 - Host keeps chip select low through a whole read.
// R6 - Chip select rising ends a read and floats serial output.
// R7 - D4H reads buffer 1, D6H buffer 2, at any rate.
// R8 - D1H and D3H read buffers, low clock rate only.
// R9 - Buffer address: dummy bits then 10 or 9 offset bits.
// R10 - Buffer read needs one dummy byte before data.
// R11 - Buffer read wraps from last byte to offset zero.
// R12 - Buffer write 84H or 87H, same address form as read.
// R13 - Written bytes fill successive offsets, wrapping, until select rises.
// R14 - 83H or 86H: program with erase, page between dummy bits.
// R15 - Select rising: erase page to ones, then program buffer, self-timed.
// R16 - 88H or 89H: program without erase, same address form.
// R17 - Select rising: program buffer into page without erase.
// R18 - Host erases the page before program without erase.
// R19 - 81H page erase, page between leading and trailing dummies.
// R20 - Select rising: page erased to all ones, self-timed.
// R21 - Busy shows on ready pin and status until done.
// R22 - MSB first, sample on rising, change on falling edge.
`timescale 1ns/1ps
`default_nettype none
module sfpb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             en_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_chk
    $error("Fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;
  assign in_ready_o  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_ptr_reg != rd_ptr_reg;
  assign out_data_o  = mem[rd_ptr_reg[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  always_ff @(posedge clk_i)
  begin
    if (en_i && push)
    begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else if (en_i)
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

module sfpb_top #(
  parameter int PAGE_W = sfpb_pkg::DOC_PAGE_W
) (
  input  wire logic CORE_CLK_I,
  input  wire logic RESET_I,
  input  wire logic CLK_EN_I,
  input  wire logic CS_N_I,
  input  wire logic SCK_I,
  input  wire logic SI_I,
  input  wire logic PAGE_512_I,
  output logic      SO_O,
  output logic      SO_OE_O,
  output logic      RDY_BUSY_O,
  output logic      STATUS_READY_O
);
  localparam int OW = sfpb_pkg::OFF_W;
  localparam int FW = 1 + OW + 8;
  if (PAGE_W < 1 || PAGE_W > sfpb_pkg::DOC_PAGE_W)
  begin : g_chk
    $error("Page number width out of range");
  end
  if (int'(sfpb_pkg::PAGE_ERASE_CYC) < int'(sfpb_pkg::LAST_OFF_STD) + 1
   || int'(sfpb_pkg::PROGRAM_CYC) < int'(sfpb_pkg::LAST_OFF_STD) + 1
   || int'(sfpb_pkg::ERASE_PROGRAM_CYC) < 2 * (int'(sfpb_pkg::LAST_OFF_STD) + 1))
  begin : g_time_chk
    $error("Busy time shorter than the page walk");
  end
  // ==========================================
  // Storage
  logic [7:0] arr_mem [0:(1 << (PAGE_W + OW))-1];
  logic [7:0] buf_mem [0:(1 << (OW + 1))-1];
  // ==========================================
  // Pin synchronisers and edges
  logic [3:0] s1_reg;
  logic [3:0] s2_reg;
  logic       sck_d_reg;
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
    begin
      s1_reg    <= 4'h2;
      s2_reg    <= 4'h2;
      sck_d_reg <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      s1_reg    <= {PAGE_512_I, SI_I, CS_N_I, SCK_I};
      s2_reg    <= s1_reg;
      sck_d_reg <= s2_reg[0];
    end
  end
  logic cs_n;
  logic bin;
  logic sck_rise;
  logic sck_fall;
  assign cs_n     = s2_reg[1];
  assign bin      = s2_reg[3];
  assign sck_rise = s2_reg[0] && !sck_d_reg && !cs_n;
  assign sck_fall = !s2_reg[0] && sck_d_reg && !cs_n;
  // ==========================================
  // Decode
  sfpb_pkg::sfpb_link_t link_reg;
  logic [2:0]  bit_cnt_reg;
  logic [3:0]  byte_cnt_reg;
  logic [7:0]  sh_reg;
  logic [7:0]  op_reg;
  logic [23:0] addr_reg;
  logic [PAGE_W-1:0] page_reg;
  logic [OW-1:0] off_reg;
  logic [7:0]  cur_reg;
  logic [7:0]  rx_byte;
  logic [23:0] addr_full;
  logic [3:0]  byte_n;
  logic        rx_done;
  logic        is_prd;
  logic        is_brd;
  logic        is_bwr;
  logic        is_pge;
  logic        is_pgn;
  logic        is_per;
  logic        buf2;
  logic [9:0]  last_off;
  logic [7:0]  src_byte;
  logic        cur_msb;
  assign rx_byte   = {sh_reg[6:0], s2_reg[2]}; // R22
  assign addr_full = {addr_reg[15:0], rx_byte};
  assign byte_n    = byte_cnt_reg + 4'h1;
  assign rx_done   = sck_rise && bit_cnt_reg == 3'h7;
  assign is_prd    = op_reg == sfpb_pkg::CMD_PAGE_READ;
  assign is_brd    = op_reg == sfpb_pkg::CMD_BUF1_RD_HS // R7
                  || op_reg == sfpb_pkg::CMD_BUF2_RD_HS
                  || op_reg == sfpb_pkg::CMD_BUF1_RD_LS // R8
                  || op_reg == sfpb_pkg::CMD_BUF2_RD_LS;
  assign is_bwr    = op_reg == sfpb_pkg::CMD_BUF1_WRITE // R12
                  || op_reg == sfpb_pkg::CMD_BUF2_WRITE;
  assign is_pge    = op_reg == sfpb_pkg::CMD_PROG_ER_B1 // R14
                  || op_reg == sfpb_pkg::CMD_PROG_ER_B2;
  assign is_pgn    = op_reg == sfpb_pkg::CMD_PROG_B1 // R16
                  || op_reg == sfpb_pkg::CMD_PROG_B2;
  assign is_per    = op_reg == sfpb_pkg::CMD_PAGE_ERASE; // R19
  assign buf2      = op_reg == sfpb_pkg::CMD_BUF2_RD_HS
                  || op_reg == sfpb_pkg::CMD_BUF2_RD_LS
                  || op_reg == sfpb_pkg::CMD_BUF2_WRITE
                  || op_reg == sfpb_pkg::CMD_PROG_ER_B2
                  || op_reg == sfpb_pkg::CMD_PROG_B2;
  assign last_off  = bin ? sfpb_pkg::LAST_OFF_BIN : sfpb_pkg::LAST_OFF_STD;
  assign src_byte  = is_prd ? arr_mem[{page_reg, off_reg}] // R3
                            : buf_mem[{buf2, off_reg}];
  assign cur_msb   = cur_reg[7];
  function automatic logic known_op(input logic [7:0] c);
    known_op = c == sfpb_pkg::CMD_PAGE_READ || c == sfpb_pkg::CMD_BUF1_RD_HS
            || c == sfpb_pkg::CMD_BUF2_RD_HS || c == sfpb_pkg::CMD_BUF1_RD_LS
            || c == sfpb_pkg::CMD_BUF2_RD_LS || c == sfpb_pkg::CMD_BUF1_WRITE
            || c == sfpb_pkg::CMD_BUF2_WRITE || c == sfpb_pkg::CMD_PROG_ER_B1
            || c == sfpb_pkg::CMD_PROG_ER_B2 || c == sfpb_pkg::CMD_PROG_B1
            || c == sfpb_pkg::CMD_PROG_B2 || c == sfpb_pkg::CMD_PAGE_ERASE;
  endfunction
  function automatic logic [OW-1:0] next_off(input logic [OW-1:0] o,
                                             input logic [9:0] l);
    next_off = (o == l) ? '0 : o + 1'b1;
  endfunction
  // ==========================================
  // Serial command engine
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
    begin
      link_reg     <= sfpb_pkg::LK_IDLE;
      bit_cnt_reg  <= '0;
      byte_cnt_reg <= '0;
      sh_reg       <= '0;
      op_reg       <= '0;
      addr_reg     <= '0;
      page_reg     <= '0;
      off_reg      <= '0;
      cur_reg      <= '0;
    end
    else if (CLK_EN_I)
    begin
      if (cs_n)
      begin
        link_reg     <= sfpb_pkg::LK_IDLE; // R6
        bit_cnt_reg  <= '0;
        byte_cnt_reg <= '0;
      end
      else if (link_reg == sfpb_pkg::LK_IDLE)
      begin
        link_reg <= sfpb_pkg::LK_HDR;
      end
      else if (sck_rise)
      begin
        sh_reg      <= rx_byte;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (rx_done)
        begin
          if (byte_cnt_reg != 4'hF)
          begin
            byte_cnt_reg <= byte_n;
          end
          case (link_reg)
            sfpb_pkg::LK_HDR:
            begin
              if (byte_cnt_reg == 4'h0)
              begin
                op_reg <= rx_byte;
                if (!known_op(rx_byte))
                begin
                  link_reg <= sfpb_pkg::LK_SKIP;
                end
              end
              else if (byte_cnt_reg < sfpb_pkg::HDR_BYTES)
              begin
                addr_reg <= addr_full;
              end
              if (byte_n == sfpb_pkg::HDR_BYTES)
              begin
                page_reg <= bin ? addr_full[sfpb_pkg::PAGE_POS_BIN +: PAGE_W] // R2
                                : addr_full[sfpb_pkg::PAGE_POS_STD +: PAGE_W]; // R1
                off_reg  <= bin ? {1'b0, addr_full[8:0]} : addr_full[9:0]; // R9
                if (is_bwr)
                begin
                  link_reg <= sfpb_pkg::LK_DIN; // R12
                end
              end
              if ((is_prd && byte_n == sfpb_pkg::PAGE_READ_START) // R1
               || (is_brd && byte_n == sfpb_pkg::BUF_READ_START)) // R10
              begin
                cur_reg  <= src_byte;
                off_reg  <= next_off(off_reg, last_off);
                link_reg <= sfpb_pkg::LK_DOUT;
              end
            end
            sfpb_pkg::LK_DOUT:
            begin
              cur_reg <= src_byte; // R3
              off_reg <= next_off(off_reg, last_off); // R4 R11
            end
            sfpb_pkg::LK_DIN:
            begin
              off_reg <= next_off(off_reg, last_off); // R13
            end
            default:
            begin
            end
          endcase
        end
      end
    end
  end
  // ==========================================
  // Serial output
  logic so_reg;
  logic so_oe_reg;
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
    begin
      so_reg    <= 1'b0;
      so_oe_reg <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      if (cs_n || link_reg != sfpb_pkg::LK_DOUT)
      begin
        so_oe_reg <= 1'b0; // R6
      end
      else if (sck_fall)
      begin
        so_reg    <= cur_reg[~bit_cnt_reg]; // R22
        so_oe_reg <= 1'b1;
      end
    end
  end
  assign SO_O    = so_reg;
  assign SO_OE_O = so_oe_reg;
  // ==========================================
  // Write buffering
  logic          push;
  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic          drain_ready;
  logic [FW-1:0] fifo_out;
  assign push = rx_done && link_reg == sfpb_pkg::LK_DIN; // R13
  sfpb_fifo #(
    .WIDTH (FW),
    .DEPTH (sfpb_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CORE_CLK_I),
    .rst_i       (RESET_I),
    .en_i        (CLK_EN_I),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({buf2, off_reg, rx_byte}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (drain_ready),
    .out_data_o  (fifo_out)
  );
  always_ff @(posedge CORE_CLK_I)
  begin
    if (CLK_EN_I && fifo_out_valid && drain_ready)
    begin
      buf_mem[fifo_out[FW-1:8]] <= fifo_out[7:0];
    end
  end
  // ==========================================
  // Self-timed program and erase
  sfpb_pkg::sfpb_op_t op_state_reg;
  logic [PAGE_W-1:0] op_page_reg;
  logic          op_buf_reg;
  logic          op_prog_reg;
  logic [OW-1:0] op_idx_reg;
  logic [15:0]   timer_reg;
  logic          ready_reg;
  logic          status_ready_reg;
  logic          launch;
  logic          arr_we;
  logic [7:0]    arr_wdata;
  assign drain_ready = op_state_reg != sfpb_pkg::OP_PROG;
  assign launch = cs_n && link_reg == sfpb_pkg::LK_HDR
               && byte_cnt_reg >= sfpb_pkg::HDR_BYTES
               && (is_pge || is_pgn || is_per)
               && op_state_reg == sfpb_pkg::OP_IDLE;
  assign arr_we = op_state_reg == sfpb_pkg::OP_ERASE
               || op_state_reg == sfpb_pkg::OP_PROG;
  assign arr_wdata = (op_state_reg == sfpb_pkg::OP_ERASE)
                   ? sfpb_pkg::ERASED_BYTE // R20
                   : arr_mem[{op_page_reg, op_idx_reg}]
                     & buf_mem[{op_buf_reg, op_idx_reg}]; // R17
  always_ff @(posedge CORE_CLK_I)
  begin
    if (CLK_EN_I && arr_we)
    begin
      arr_mem[{op_page_reg, op_idx_reg}] <= arr_wdata;
    end
  end
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
    begin
      op_state_reg     <= sfpb_pkg::OP_IDLE;
      op_page_reg      <= '0;
      op_buf_reg       <= 1'b0;
      op_prog_reg      <= 1'b0;
      op_idx_reg       <= '0;
      timer_reg        <= '0;
      ready_reg        <= 1'b1;
      status_ready_reg <= 1'b1;
    end
    else if (CLK_EN_I)
    begin
      if (timer_reg != 16'h0)
      begin
        timer_reg <= timer_reg - 16'h1;
      end
      case (op_state_reg)
        sfpb_pkg::OP_IDLE:
        begin
          if (launch)
          begin
            op_page_reg      <= page_reg;
            op_buf_reg       <= buf2;
            op_prog_reg      <= is_pge || is_pgn;
            op_idx_reg       <= '0;
            op_state_reg     <= is_pgn ? sfpb_pkg::OP_PROG : sfpb_pkg::OP_ERASE; // R15
            timer_reg        <= is_pge ? sfpb_pkg::ERASE_PROGRAM_CYC
                              : is_pgn ? sfpb_pkg::PROGRAM_CYC
                              : sfpb_pkg::PAGE_ERASE_CYC;
            ready_reg        <= 1'b0; // R21
            status_ready_reg <= 1'b0;
          end
        end
        sfpb_pkg::OP_ERASE:
        begin
          op_idx_reg <= next_off(op_idx_reg, last_off);
          if (op_idx_reg == last_off)
          begin
            op_state_reg <= op_prog_reg ? sfpb_pkg::OP_PROG : sfpb_pkg::OP_WAIT; // R15
          end
        end
        sfpb_pkg::OP_PROG:
        begin
          op_idx_reg <= next_off(op_idx_reg, last_off);
          if (op_idx_reg == last_off)
          begin
            op_state_reg <= sfpb_pkg::OP_WAIT;
          end
        end
        sfpb_pkg::OP_WAIT:
        begin
          if (timer_reg == 16'h0)
          begin
            op_state_reg     <= sfpb_pkg::OP_IDLE;
            ready_reg        <= 1'b1; // R21
            status_ready_reg <= 1'b1;
          end
        end
        default:
        begin
          op_state_reg <= sfpb_pkg::OP_IDLE;
        end
      endcase
    end
  end
  assign RDY_BUSY_O     = ready_reg;
  assign STATUS_READY_O = status_ready_reg;
  // ==========================================
  // Checks
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I || !CLK_EN_I);
  a_cs_high_hiz: assert property (cs_n |=> !SO_OE_O) // R6
    else $error("Output driven after select rose");
  a_oe_only_out: assert property (SO_OE_O |-> $past(link_reg) == sfpb_pkg::LK_DOUT) // R3
    else $error("Output driven outside data phase");
  a_msb_first: assert property ((sck_fall && link_reg == sfpb_pkg::LK_DOUT
      && bit_cnt_reg == 3'h0) |=> SO_O == $past(cur_msb)) // R22
    else $error("First bit is not the byte msb");
  a_page_wrap: assert property ((rx_done && link_reg == sfpb_pkg::LK_DOUT && is_prd
      && off_reg == last_off) |=> off_reg == '0) // R4
    else $error("Page read did not wrap in page");
  a_buf_wrap: assert property ((rx_done && link_reg == sfpb_pkg::LK_DOUT && is_brd
      && off_reg == last_off) |=> off_reg == '0) // R11
    else $error("Buffer read did not wrap");
  a_read_start: assert property ($rose(link_reg == sfpb_pkg::LK_DOUT) |->
      byte_cnt_reg == (is_prd ? sfpb_pkg::PAGE_READ_START : sfpb_pkg::BUF_READ_START)) // R10
    else $error("Read data began at wrong byte");
  a_ready_match: assert property (RDY_BUSY_O == (op_state_reg == sfpb_pkg::OP_IDLE)
      && STATUS_READY_O == RDY_BUSY_O) // R21
    else $error("Ready does not track operation");
  a_erase_ones: assert property ((arr_we && op_state_reg == sfpb_pkg::OP_ERASE)
      |-> arr_wdata == sfpb_pkg::ERASED_BYTE) // R20
    else $error("Erase wrote a non-erased value");
  a_erase_then_prog: assert property ((op_state_reg == sfpb_pkg::OP_ERASE && op_prog_reg
      && op_idx_reg == last_off) |=> op_state_reg == sfpb_pkg::OP_PROG) // R15
    else $error("Program did not follow erase");
  a_prog_no_erase: assert property ((launch && is_pgn)
      |=> op_state_reg == sfpb_pkg::OP_PROG) // R17
    else $error("Program without erase erased");
endmodule
`default_nettype wire

// File: tb/sfpb_host.sv
`timescale 1ns/1ps
`default_nettype none
module sfpb_host (
  input  wire logic clk_i,
  input  wire logic so_i,
  input  wire logic so_oe_i,
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o
);
  logic       act;
  logic [7:0] rx_q[$];
  initial
  begin
    act = 1'b0;
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  // ==========================================
  // Idle data line toggles every cycle
  always @(posedge clk_i)
  begin
    if (!act)
      si_o <= ~si_o;
  end
  // ==========================================
  // One frame, mode 0, bits sampled at the rise
  task automatic frame(input logic [7:0] tx[$], input int nrd);
    logic [7:0] b;
    logic [7:0] r;
    rx_q.delete();
    act = 1'b1;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = 0; i < tx.size() + nrd; i++)
    begin
      b = (i < tx.size()) ? tx[i] : 8'h00;
      for (int k = 7; k >= 0; k--)
      begin
        sck_o <= 1'b0;
        si_o <= b[k];
        repeat (4) @(posedge clk_i);
        r = {r[6:0], so_oe_i ? so_i : 1'bx};
        sck_o <= 1'b1;
        repeat (4) @(posedge clk_i);
      end
      if (i >= tx.size())
        rx_q.push_back(r);
    end
    sck_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    act = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb/sfpb_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sfpb_bench;
  logic       clk = 1'b0;
  logic       rst;
  logic       p512;
  logic       cs_n;
  logic       sck;
  logic       si;
  logic       so;
  logic       so_oe;
  logic       rdy;
  logic       st_rdy;
  logic       en = 1'b1;
  int         fails = 0;
  int         n_checks = 0;
  int         cyc = 0;
  logic [7:0] wq[$];
  always #50 clk = ~clk;
  sfpb_top #(.PAGE_W(2)) i_sfpb_top (
    .CORE_CLK_I(clk), .RESET_I(rst), .CLK_EN_I(en), .CS_N_I(cs_n),
    .SCK_I(sck), .SI_I(si), .PAGE_512_I(p512), .SO_O(so),
    .SO_OE_O(so_oe), .RDY_BUSY_O(rdy), .STATUS_READY_O(st_rdy));
  sfpb_host i_sfpb_host (
    .clk_i(clk), .so_i(so), .so_oe_i(so_oe),
    .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
  // ==========================================
  // Helpers
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      stop_test();
    end
  end
  function automatic logic [23:0] ad(input int pg, input int off);
    return p512 ? 24'(pg * 512 + off) : 24'(pg * 1024 + off);
  endfunction
  task automatic op(input logic [7:0] c, input logic [23:0] a, input int nd, input int nrd);
    logic [7:0] q[$];
    q = {c, a[23:16], a[15:8], a[7:0]};
    repeat (nd) q.push_back(8'h00);
    q = {q, wq};
    wq.delete();
    i_sfpb_host.frame(q, nrd);
  endtask
  task automatic rx(input string nm, input logic [7:0] e[$]);
    foreach (e[i]) chk(nm, e[i], i_sfpb_host.rx_q[i]);
  endtask
  task automatic busy(input int lim);
    int n = 0;
    chk("busy pin", 8'h00, 8'(rdy));
    chk("status ready", 8'h00, 8'(st_rdy));
    while (rdy !== 1'b1 && n < lim + 50)
    begin
      @(posedge clk);
      n++;
    end
    // Ready returns the cycle after the timer runs out
    chk("busy length", 8'h01, 8'(n > lim - 29 && n <= lim + 1));
  endtask
  task automatic do_reset(input logic m);
    rst <= 1'b1;
    p512 <= m;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    chk("oe at reset", 8'h00, 8'(so_oe));
    chk("ready at reset", 8'h01, 8'(rdy));
    chk("status at reset", 8'h01, 8'(st_rdy));
  endtask
  task automatic t_bufs();
    wq = {8'hA1, 8'hB2, 8'hC3};
    op(8'h84, ad(0, 526), 0, 0);
    op(8'hD4, ad(0, 526), 1, 3);
    rx("buf1 wrap", {8'hA1, 8'hB2, 8'hC3});
    repeat (2) @(posedge clk);
    chk("oe after read", 8'h00, 8'(so_oe));
    wq = {8'h5A, 8'h6B};
    op(8'h87, ad(0, 0), 0, 0);
    op(8'hD3, ad(0, 0), 1, 2);
    rx("buf2 slow", {8'h5A, 8'h6B});
    op(8'hD1, ad(0, 527), 1, 2);
    rx("buf1 slow", {8'hB2, 8'hC3});
    op(8'hD6, ad(0, 1), 1, 1);
    rx("buf2 fast", {8'h6B});
  endtask
  task automatic t_prog();
    op(8'h83, ad(1, 0), 0, 0);
    busy(int'(sfpb_pkg::ERASE_PROGRAM_CYC));
    op(8'hD2, ad(1, 526), 4, 3);
    rx("page wrap", {8'hA1, 8'hB2, 8'hC3});
    op(8'hD4, ad(0, 527), 1, 1);
    rx("buf kept", {8'hB2});
  endtask
  task automatic t_erase();
    op(8'h81, ad(1, 0), 0, 0);
    // Frozen cycles must not count towards the busy time
    en <= 1'b0;
    repeat (100) @(posedge clk);
    en <= 1'b1;
    busy(int'(sfpb_pkg::PAGE_ERASE_CYC));
    op(8'hD2, ad(1, 526), 4, 2);
    rx("erased", {8'hFF, 8'hFF});
    op(8'h89, ad(1, 0), 0, 0);
    busy(int'(sfpb_pkg::PROGRAM_CYC));
    op(8'hD2, ad(1, 0), 4, 2);
    rx("no erase prog", {8'h5A, 8'h6B});
  endtask
  task automatic t_codes();
    op(8'h81, ad(2, 0), 0, 0);
    busy(int'(sfpb_pkg::PAGE_ERASE_CYC));
    op(8'h88, ad(2, 0), 0, 0);
    busy(int'(sfpb_pkg::PROGRAM_CYC));
    op(8'hD2, ad(2, 527), 4, 2);
    rx("prog buf1", {8'hB2, 8'hC3});
    op(8'h86, ad(3, 0), 0, 0);
    busy(int'(sfpb_pkg::ERASE_PROGRAM_CYC));
    op(8'hD2, ad(3, 0), 4, 2);
    rx("prog buf2", {8'h5A, 8'h6B});
  endtask
  task automatic t_bin();
    do_reset(1'b1);
    wq = {8'h3C, 8'h4D};
    op(8'h84, ad(0, 511), 0, 0);
    op(8'hD4, ad(0, 511), 1, 2);
    rx("bin buf wrap", {8'h3C, 8'h4D});
    op(8'h83, ad(2, 0), 0, 0);
    busy(int'(sfpb_pkg::ERASE_PROGRAM_CYC));
    op(8'hD2, ad(2, 511), 4, 2);
    rx("bin page wrap", {8'h3C, 8'h4D});
  endtask
  initial
  begin
    rst = 1'b1;
    p512 = 1'b0;
    do_reset(1'b0);
    t_reset();
    t_bufs();
    t_prog();
    t_erase();
    t_codes();
    t_bin();
    stop_test();
  end
endmodule
`default_nettype wire
